//--- rtl/clock_select_and_ready_sequencer.sv
// clock selection, prescaling, gating and ready sequencing for the power unit
//
// Behaviour
// - without transceiver bias the usb function is held to full speed
// - transceiver pll lock flag rises once locked; software waits on it
// - master source chooses slow, main or pll; slow after reset
// - master prescaler divides by 1..64 in powers of two; divide-by-1 at reset
// - divider code 0,1,2 gives master as processor clock divided by 1,2,4
// - master ready rises after each master config write once the clock settles
// - any source or prescale change drops master ready until clocks are stable
// - with pll as master source, ready stays low while pll is unlocked
// - while pll is unlocked main clock substitutes as master source
// - two programmable outputs enabled by set, disabled by clear, off at reset
// - programmable output source chooses main, slow or pll; slow at reset
// - programmable output prescaler divides by 1..64; divide-by-1 at reset
// - programmable output ready flag rises once that output runs
// - a programmable config word is taken whole in one write
// - nineteen peripheral clocks gated by set and clear, equal to master clock
// - switch latency bounded; up to 64 extra new-source cycles when prescaling
// - peripheral bit n belongs to peripheral identifier n
// - pll lock rises after the programmed number of slow clock cycles
// - processor clock stops on clear write; interrupt or reset restarts it
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// power-of-two prescaler on a sampled clock level, with a settle tracker

module clock_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic srcLevel,
  input wire logic [2:0] code,
  input wire logic restart,
  output logic divLevel,
  output logic settled
);
  logic prevLevel_r;
  logic [clock_select_pkg::PRESCALE_CNT_WIDTH-1:0] edgeCnt_r;
  logic [6:0] waitCnt_r;
  logic settled_r;
  logic divLevel_r;

  // source rising edge and the counter bit that carries the division
  wire logic srcRise = srcLevel & ~prevLevel_r;
  wire logic [2:0] clampCode = (code > clock_select_pkg::PRESCALE_MAX_CODE) ?
                               clock_select_pkg::PRESCALE_MAX_CODE : code;
  wire logic [2:0] tapIdx = clampCode - 3'h1;
  wire logic divNxt = (clampCode == 3'h0) ? srcLevel : edgeCnt_r[tapIdx];
  // a busy prescaler earns the extra edges, never more
  wire logic [6:0] waitLoad = (clampCode == 3'h0) ? clock_select_pkg::SETTLE_EDGES :
                              7'(clock_select_pkg::SETTLE_EDGES +
                                 clock_select_pkg::PRESCALE_EXTRA_EDGES);
  wire logic waitDone = (waitCnt_r == 7'h00);

  assign divLevel = divLevel_r;
  assign settled = settled_r;

  // edge counting runs free; the divided level follows one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      prevLevel_r <= 1'b0;
      edgeCnt_r <= '0;
      divLevel_r <= 1'b0;
    end else begin
      prevLevel_r <= srcLevel;
      edgeCnt_r <= srcRise ? edgeCnt_r + 6'h01 : edgeCnt_r;
      divLevel_r <= divNxt;
    end
  end

  // settle tracker: a restart reloads, edges of the new source count down
  always_ff @(posedge clk) begin
    if (rst) begin
      waitCnt_r <= 7'h00;
      settled_r <= 1'b1;
    end else if (restart) begin
      waitCnt_r <= waitLoad;
      settled_r <= 1'b0;
    end else begin
      waitCnt_r <= (srcRise && !waitDone) ? waitCnt_r - 7'h01 : waitCnt_r;
      settled_r <= waitDone;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: selection, gating, lock timing, status and interrupt

module clock_select_and_ready_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic slowClk,
  input wire logic mainClk,
  input wire logic pllClk,
  input wire logic usbPllCfgWr,
  input wire clock_select_pkg::usb_pll_cfg_s usbPllCfg,
  input wire logic pllCfgWr,
  input wire clock_select_pkg::pll_cfg_s pllCfg,
  input wire logic masterCfgWr,
  input wire clock_select_pkg::master_cfg_s masterCfg,
  input wire logic [1:0] progCfgWr,
  input wire clock_select_pkg::clock_cfg_s progCfg,
  input wire logic sysClkSetWr,
  input wire logic sysClkClrWr,
  input wire clock_select_pkg::sys_clk_s sysClkData,
  input wire logic periphSetWr,
  input wire logic periphClrWr,
  input wire logic [31:0] periphData,
  input wire logic irqMaskSetWr,
  input wire logic irqMaskClrWr,
  input wire clock_select_pkg::power_status_s irqMaskData,
  input wire logic wakeIrq,
  output logic masterClk,
  output logic procClk,
  output logic [1:0] progClk,
  output logic [31:0] periphClk,
  output logic highSpeedAllowed,
  output clock_select_pkg::power_status_s powerStatus,
  output clock_select_pkg::sys_clk_s sysClkState,
  output logic [31:0] periphClkState,
  output clock_select_pkg::master_cfg_s masterCfgState,
  output logic irq
);
  clock_select_pkg::master_cfg_s masterCfg_r;
  clock_select_pkg::clock_cfg_s progCfg_r [clock_select_pkg::PROG_COUNT];
  clock_select_pkg::usb_pll_cfg_s usbCfg_r;
  clock_select_pkg::power_status_s status_r;
  clock_select_pkg::power_status_s irqMask_r;
  logic [3:0] usbLockCnt_r;
  logic [5:0] pllLockCnt_r;
  logic usbLocked_r;
  logic pllLocked_r;
  logic pllRunning_r;
  logic slowPrev_r;
  logic procEn_r;
  logic [1:0] progEn_r;
  logic [31:0] periphEn_r;
  logic procClk_r;
  logic [1:0] progClk_r;
  logic [31:0] periphClk_r;
  logic highSpeed_r;
  logic irq_r;
  logic masterLevel;
  logic masterSettled;
  logic [1:0] progLevel;
  logic [1:0] progSettled;

  //////////////////////////////////////////////////////////////////////////////
  // source decode and selection

  wire logic slowRise = slowClk & ~slowPrev_r;
  wire logic masterWantsPll = masterCfg_r.sel.clockSourceSelect[1];
  // an unlocked pll is never handed to the master path
  wire logic masterOnMain = masterWantsPll & ~pllLocked_r;
  wire logic masterSrc = masterOnMain ? mainClk :
                         masterWantsPll ? pllClk :
                         (masterCfg_r.sel.clockSourceSelect == clock_select_pkg::SRC_MAIN) ?
                         mainClk : slowClk;
  wire logic pllLockRise = pllCfgWr ? 1'b0 : (pllRunning_r && !pllLocked_r &&
                                              slowRise && pllLockCnt_r <= 6'h01);
  // each write of the master word, and each pll relock while the master selects pll, restart settling
  wire logic masterRestart = masterCfgWr | (masterWantsPll & pllLockRise);
  wire logic masterReadyNxt = masterSettled & ~(masterWantsPll & ~pllLocked_r);
  wire logic [2:0] masterDivCode = {1'b0, masterCfg_r.masterDividerCode};

  //////////////////////////////////////////////////////////////////////////////
  // master prescaler, then the divider from processor to master clock

  clock_prescaler masterPresc (
    .clk(clk),
    .rst(rst),
    .srcLevel(masterSrc),
    .code(masterCfg_r.sel.prescaleCode),
    .restart(masterRestart),
    .divLevel(masterLevel),
    .settled(masterSettled)
  );

  // with divider code 1 or 2 the master tap sits one flop behind the processor clock it divides; code 0 keeps them aligned
  clock_prescaler masterDiv (
    .clk(clk),
    .rst(rst),
    .srcLevel(masterLevel),
    .code(masterDivCode),
    .restart(1'b0),
    .divLevel(masterClk),
    .settled()
  );

  //////////////////////////////////////////////////////////////////////////////
  // programmable outputs, one prescaler each

  genvar gi;
  generate
    for (gi = 0; gi < clock_select_pkg::PROG_COUNT; gi++) begin : gProg
      wire logic [1:0] srcSel = progCfg_r[gi].clockSourceSelect;
      // no glitch guard here: software disables before reconfiguring
      wire logic progSrc = srcSel[1] ? pllClk :
                           (srcSel == clock_select_pkg::SRC_MAIN) ? mainClk : slowClk;
      wire logic progRestart = progCfgWr[gi] | (sysClkSetWr & sysClkData.progOutput[gi]);

      clock_prescaler progPresc (
        .clk(clk),
        .rst(rst),
        .srcLevel(progSrc),
        .code(progCfg_r[gi].prescaleCode),
        .restart(progRestart),
        .divLevel(progLevel[gi]),
        .settled(progSettled[gi])
      );

      // whole word taken in one write, no field order needed
      always_ff @(posedge clk) begin
        if (rst) begin
          progCfg_r[gi] <= clock_select_pkg::PROG_CFG_RESET;
        end else if (progCfgWr[gi]) begin
          progCfg_r[gi] <= progCfg;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // configuration words

  // master word taken whole; ordering of source and prescale is up to software
  always_ff @(posedge clk) begin
    if (rst) begin
      masterCfg_r <= clock_select_pkg::MASTER_CFG_RESET;
    end else if (masterCfgWr) begin
      masterCfg_r <= masterCfg;
    end
  end

  // transceiver pll word; lock counts slow edges from the write
  always_ff @(posedge clk) begin
    if (rst) begin
      usbCfg_r <= '0;
      usbLockCnt_r <= 4'h0;
      usbLocked_r <= 1'b0;
    end else if (usbPllCfgWr) begin
      usbCfg_r <= usbPllCfg;
      usbLockCnt_r <= usbPllCfg.pllStartupCount;
      usbLocked_r <= 1'b0;
    end else if (usbCfg_r.usbPllEnable && !usbLocked_r && slowRise) begin
      usbLockCnt_r <= (usbLockCnt_r == 4'h0) ? 4'h0 : usbLockCnt_r - 4'h1;
      usbLocked_r <= (usbLockCnt_r <= 4'h1);
    end
  end

  // main pll word; a rewrite unlocks until the count of slow edges passes
  always_ff @(posedge clk) begin
    if (rst) begin
      pllRunning_r <= 1'b0;
      pllLockCnt_r <= 6'h00;
      pllLocked_r <= 1'b0;
    end else if (pllCfgWr) begin
      pllRunning_r <= pllCfg.pllEnable;
      pllLockCnt_r <= pllCfg.pllStartupCount;
      pllLocked_r <= 1'b0;
    end else if (pllRunning_r && !pllLocked_r && slowRise) begin
      pllLockCnt_r <= (pllLockCnt_r == 6'h00) ? 6'h00 : pllLockCnt_r - 6'h01;
      pllLocked_r <= pllLockRise;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock gating state

  // interrupt or reset restarts the processor clock over a clear
  wire logic procEnNxt = wakeIrq ? 1'b1 :
                         (sysClkClrWr & sysClkData.processorClock) ? 1'b0 : procEn_r;
  wire logic [1:0] progClr = sysClkClrWr ? sysClkData.progOutput : 2'h0;
  wire logic [1:0] progSet = sysClkSetWr ? sysClkData.progOutput : 2'h0;
  wire logic [31:0] perClr = periphClrWr ? periphData : 32'h0000_0000;
  wire logic [31:0] perSet = periphSetWr ? periphData : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      procEn_r <= clock_select_pkg::PROC_CLK_RESET;
      progEn_r <= 2'h0;
      periphEn_r <= 32'h0000_0000;
    end else begin
      procEn_r <= procEnNxt;
      progEn_r <= (progEn_r & ~progClr) | progSet;
      periphEn_r <= ((periphEn_r & ~perClr) | perSet) &
                    clock_select_pkg::PERIPH_IMPL_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // gated clock outputs, each from a flop

  always_ff @(posedge clk) begin
    if (rst) begin
      procClk_r <= 1'b0;
      progClk_r <= 2'h0;
      periphClk_r <= 32'h0000_0000;
    end else begin
      procClk_r <= masterLevel & procEn_r;
      progClk_r <= progLevel & progEn_r;
      periphClk_r <= {32{masterClk}} & periphEn_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status, high speed permission and interrupt

  wire clock_select_pkg::power_status_s statusNxt = '{
    progOutputReady: progSettled & progEn_r,
    masterClockReady: masterReadyNxt & ~masterRestart,
    pllLocked: pllLocked_r,
    usbPllLocked: usbLocked_r
  };
  wire clock_select_pkg::power_status_s maskNxt =
    (irqMask_r & ~(irqMaskClrWr ? irqMaskData : '0)) | (irqMaskSetWr ? irqMaskData : '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= '0;
      irqMask_r <= '0;
      highSpeed_r <= 1'b0;
      irq_r <= 1'b0;
      slowPrev_r <= 1'b0;
    end else begin
      status_r <= statusNxt;
      irqMask_r <= maskNxt;
      // without bias only full speed is offered, pll running or not
      highSpeed_r <= usbCfg_r.transceiverBiasEnable & usbLocked_r;
      irq_r <= |(status_r & irqMask_r);
      slowPrev_r <= slowClk;
    end
  end

  assign procClk = procClk_r;
  assign progClk = progClk_r;
  assign periphClk = periphClk_r;
  assign highSpeedAllowed = highSpeed_r;
  assign powerStatus = status_r;
  assign sysClkState = '{progOutput: progEn_r, processorClock: procEn_r};
  assign periphClkState = periphEn_r;
  assign masterCfgState = masterCfg_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

//--- rtl/clock_select_pkg.sv
// shared types and constants for the clock select and ready sequencer
`default_nettype none
package clock_select_pkg;

  // source codes of a clock selection field; code 3 also means pll
  typedef enum logic [1:0] {
    SRC_SLOW = 2'h0,
    SRC_MAIN = 2'h1,
    SRC_PLL = 2'h2,
    SRC_PLL_ALT = 2'h3
  } src_e;

  // selection word: prescale code in bits 4:2, source in bits 1:0
  typedef struct packed {
    logic [2:0] prescaleCode;
    logic [1:0] clockSourceSelect;
  } clock_cfg_s;

  // master clock config word: divider code above the selection
  typedef struct packed {
    logic [1:0] masterDividerCode;
    clock_cfg_s sel;
  } master_cfg_s;

  // transceiver pll config word
  typedef struct packed {
    logic [3:0] pllStartupCount;
    logic transceiverBiasEnable;
    logic usbPllEnable;
  } usb_pll_cfg_s;

  // main pll config word, startup count in slow clock cycles
  typedef struct packed {
    logic [5:0] pllStartupCount;
    logic pllEnable;
  } pll_cfg_s;

  // system clock set / clear / state word
  typedef struct packed {
    logic [1:0] progOutput;
    logic processorClock;
  } sys_clk_s;

  // ready and lock flags, also the layout of the interrupt mask
  typedef struct packed {
    logic [1:0] progOutputReady;
    logic masterClockReady;
    logic pllLocked;
    logic usbPllLocked;
  } power_status_s;

  localparam int PROG_COUNT = 2;
  localparam int PERIPH_WIDTH = 32;
  // peripheral identifiers 2..20: nineteen gated clocks
  localparam logic [31:0] PERIPH_IMPL_MASK = 32'h001F_FFFC;
  localparam logic [2:0] PRESCALE_MAX_CODE = 3'h6;
  localparam int PRESCALE_CNT_WIDTH = 6;
  // new-source edges before a switch counts as settled
  localparam logic [6:0] SETTLE_EDGES = 7'h02;
  // extra new-source edges allowed while the prescaler divides
  localparam logic [6:0] PRESCALE_EXTRA_EDGES = 7'h40;
  localparam master_cfg_s MASTER_CFG_RESET = '0;
  localparam clock_cfg_s PROG_CFG_RESET = '0;
  localparam logic PROC_CLK_RESET = 1'b1;

endpackage
`default_nettype wire

//--- bench/clock_select_monitor.sv
// port checker for the clock select and ready sequencer, bound below
`default_nettype none
module clock_select_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic periphSetWr,
  input wire logic periphClrWr,
  input wire logic [31:0] periphData,
  input wire logic [31:0] periphClkState,
  input wire logic masterCfgWr,
  input wire clock_select_pkg::master_cfg_s masterCfg,
  input wire clock_select_pkg::master_cfg_s masterCfgState,
  input wire clock_select_pkg::power_status_s powerStatus,
  input wire logic sysClkClrWr,
  input wire clock_select_pkg::sys_clk_s sysClkData,
  input wire clock_select_pkg::sys_clk_s sysClkState,
  input wire logic wakeIrq,
  input wire logic highSpeedAllowed
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] IMPL = clock_select_pkg::PERIPH_IMPL_MASK;
  // one domain: every property samples on clk and is off during reset
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // peripheral gating: only existing ids, set and clear land the next cycle
  AST_PERIPH_IMPL: assert property ((periphClkState & ~IMPL) == '0)
    else $error("absent peripheral enabled");
  AST_PERIPH_SET: assert property (periphSetWr |=>
    (periphClkState & $past(periphData) & IMPL) == ($past(periphData) & IMPL))
    else $error("peripheral set lost");
  AST_PERIPH_CLR: assert property (periphClrWr && !periphSetWr |=>
    (periphClkState & $past(periphData)) == '0)
    else $error("peripheral clear lost");

  ////////////////////////////////////////////////////////////////////////////////
  // master config: ready drops at once, the word is taken whole
  AST_MASTER_DROP: assert property (masterCfgWr |=> !powerStatus.masterClockReady)
    else $error("master ready not dropped");
  AST_MASTER_STATE: assert property (masterCfgWr |=> masterCfgState == $past(masterCfg))
    else $error("master config not taken");

  ////////////////////////////////////////////////////////////////////////////////
  // processor idle: a pending interrupt wins over the stop request
  AST_PROC_STOP: assert property (sysClkClrWr && sysClkData.processorClock && !wakeIrq
    |=> !sysClkState.processorClock)
    else $error("processor clock not stopped");
  AST_PROC_WAKE: assert property (wakeIrq |=> sysClkState.processorClock)
    else $error("processor clock not restarted");
  // high speed only follows a locked transceiver pll
  AST_HS_LOCK: assert property ($rose(highSpeedAllowed) |->
    ##[0:2] powerStatus.usbPllLocked)
    else $error("high speed without lock");

  cover property ($rose(powerStatus.masterClockReady));
  cover property ($fell(sysClkState.processorClock));
  cover property ($rose(highSpeedAllowed));
endmodule
bind clock_select_and_ready_sequencer clock_select_checker chk (.clk, .rst, .periphSetWr,
  .periphClrWr, .periphData, .periphClkState, .masterCfgWr, .masterCfg, .masterCfgState,
  .powerStatus, .sysClkClrWr, .sysClkData, .sysClkState, .wakeIrq, .highSpeedAllowed);
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the clock select and ready sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slowClk = 1'b0, mainClk = 1'b0, pllClk = 1'b0, wakeIrq = 1'b0;
  logic usbPllCfgWr = 1'b0, pllCfgWr = 1'b0, masterCfgWr = 1'b0, sysClkSetWr = 1'b0;
  logic sysClkClrWr = 1'b0, periphSetWr = 1'b0, periphClrWr = 1'b0;
  logic irqMaskSetWr = 1'b0, irqMaskClrWr = 1'b0;
  logic [1:0] progCfgWr = 2'h0;
  logic [31:0] periphData = 32'h0;
  clock_select_pkg::usb_pll_cfg_s usbPllCfg = '0;
  clock_select_pkg::pll_cfg_s pllCfg = '0;
  clock_select_pkg::master_cfg_s masterCfg = '0;
  clock_select_pkg::clock_cfg_s progCfg = '0;
  clock_select_pkg::sys_clk_s sysClkData = '0;
  clock_select_pkg::power_status_s irqMaskData = '0;
  logic masterClk, procClk, highSpeedAllowed, irq;
  logic [1:0] progClk;
  logic [31:0] periphClk, periphClkState;
  clock_select_pkg::power_status_s powerStatus;
  clock_select_pkg::sys_clk_s sysClkState;
  clock_select_pkg::master_cfg_s masterCfgState;
  int bad_count = 0;
  int total_checks = 0;
  int phase = 0;
  int srcPer [4] = '{10, 6, 4, 4};
  logic [31:0] seed = 32'h61F5;

  clock_select_and_ready_sequencer DUT (.clk, .rst, .slowClk, .mainClk, .pllClk, .usbPllCfgWr,
    .usbPllCfg, .pllCfgWr, .pllCfg, .masterCfgWr, .masterCfg, .progCfgWr, .progCfg,
    .sysClkSetWr, .sysClkClrWr, .sysClkData, .periphSetWr, .periphClrWr, .periphData,
    .irqMaskSetWr, .irqMaskClrWr, .irqMaskData, .wakeIrq, .masterClk, .procClk, .progClk,
    .periphClk, .highSpeedAllowed, .powerStatus, .sysClkState, .periphClkState,
    .masterCfgState, .irq);

  ////////////////////////////////////////////////////////////////////////////////
  // system clock and source levels; sources stay below half of clk so none is missed
  always #50 clk = ~clk;
  always @(posedge clk) begin
    phase <= phase + 1;
    if (phase % 5 == 4) slowClk <= ~slowClk;
    if (phase % 3 == 2) mainClk <= ~mainClk;
    if (phase % 2 == 1) pllClk <= ~pllClk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic pick(input int s);
    logic [4:0] v;
    v = {periphClk[4], progClk, procClk, masterClk};
    return v[s];
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    bad_count++;
    $display("wrong value at %0t ns: %s", $time, m);
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chkv(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) fail(m);
  endtask

  task automatic chkp(input int got, input int lo, input int hi, input string m);
    total_checks++;
    if (got < lo || got > hi) fail(m);
  endtask

  // one write strobe; all data buses carry the word, only one strobe rises
  task automatic strobe(input int w, input logic [31:0] d);
    @(posedge clk);
    periphData <= d;
    sysClkData <= d[2:0];
    irqMaskData <= d[4:0];
    masterCfg <= d[6:0];
    usbPllCfg <= d[5:0];
    pllCfg <= d[6:0];
    progCfg <= d[4:0];
    case (w)
      0: periphSetWr <= 1'b1;
      1: periphClrWr <= 1'b1;
      2: sysClkSetWr <= 1'b1;
      3: sysClkClrWr <= 1'b1;
      4: irqMaskSetWr <= 1'b1;
      5: irqMaskClrWr <= 1'b1;
      6: masterCfgWr <= 1'b1;
      7: usbPllCfgWr <= 1'b1;
      8: pllCfgWr <= 1'b1;
      default: progCfgWr <= 2'(w - 8);
    endcase
    @(posedge clk);
    {periphSetWr, periphClrWr, sysClkSetWr, sysClkClrWr, irqMaskSetWr} <= '0;
    {irqMaskClrWr, masterCfgWr, usbPllCfgWr, pllCfgWr, progCfgWr} <= '0;
    #1;
  endtask

  task automatic waitst(input int b, output int n);
    n = 0;
    while (powerStatus[b] !== 1'b1 && n < 1500) begin
      tick();
      n++;
    end
    if (n == 1500) begin
      fail("flag timeout");
      stop_test();
    end
  endtask

  // cycles between two rising edges of a sampled output clock
  task automatic period(input int s, output int n);
    int e;
    logic p;
    e = 0;
    n = 0;
    p = pick(s);
    for (int k = 0; k < 2000 && e < 2; k++) begin
      tick();
      n = (e == 1) ? n + 1 : 0;
      if (pick(s) && !p) e++;
      p = pick(s);
    end
    if (e < 2) begin
      fail("clock timeout");
      stop_test();
    end
  endtask

  task automatic mwrite(input logic [6:0] v, input int pp, input int mp);
    int n;
    strobe(6, v);
    tick();
    chkv(masterCfgState, v, "master config");
    chkv(powerStatus.masterClockReady, 0, "ready low");
    waitst(2, n);
    chkp(n, 1, srcPer[v[1:0]] * 66 + 8, "switch latency");
    period(1, n);
    chkp(n, pp, pp, "processor period");
    period(0, n);
    chkp(n, mp, mp, "master period");
  endtask

  task automatic reset_run(input int k);
    int n;
    @(posedge clk);
    rst <= 1'b1;
    repeat (k) @(posedge clk);
    rst <= 1'b0;
    tick();
    chkv(sysClkState, 32'h1, "system clocks");
    chkv(periphClkState, 32'h0, "peripherals");
    chkv(masterCfgState, 32'h0, "master config");
    chkv(irq, 32'h0, "interrupt");
    chkv(powerStatus, 32'h4, "status after reset");
    chkv(highSpeedAllowed, 32'h0, "full speed after reset");
    period(0, n);
    chkp(n, 10, 10, "slow master");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    logic [31:0] d;
    logic [31:0] pm;
    reset_run(4);
    pm = 32'h0;
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'h110 : rnd();
      strobe(d[0], d);
      pm = d[0] ? pm & ~d : pm | (d & clock_select_pkg::PERIPH_IMPL_MASK);
      tick();
      chkv(periphClkState, pm, "peripheral state");
      chkv(periphClk & ~pm, 32'h0, "gated peripheral");
    end
    strobe(0, 32'h10);
    strobe(2, 32'h6);
    tick();
    chkv(sysClkState, 32'h7, "outputs on");
    strobe(3, 32'h1);
    tick();
    chkv(sysClkState, 32'h6, "processor stopped");
    @(posedge clk);
    wakeIrq <= 1'b1;
    @(posedge clk);
    wakeIrq <= 1'b0;
    tick();
    chkv(sysClkState, 32'h7, "processor woken");
    strobe(3, 32'h6);
    tick();
    chkv(sysClkState, 32'h1, "outputs off");
    // to main: source first, then prescaler; then divider codes 0 to 2
    mwrite(7'h01, 6, 6);
    mwrite(7'h11, 96, 96);
    for (int m = 0; m < 3; m++) mwrite({m[1:0], 5'h05}, 12, 12 << m);
    period(4, n);
    chkp(n, 48, 48, "peripheral clock");
    strobe(8, 32'h15);
    waitst(1, n);
    chkp(n, 88, 104, "pll lock time");
    mwrite(7'h01, 6, 6);
    mwrite(7'h02, 4, 4);
    strobe(8, 32'h15);
    repeat (2) tick();
    chkv(powerStatus[2:1], 32'h0, "ready and lock low");
    period(0, n);
    period(0, n);
    chkp(n, 6, 6, "main substitutes");
    waitst(1, n);
    waitst(2, n);
    period(0, n);
    chkp(n, 4, 4, "back on pll");
    // transceiver pll without and with bias
    strobe(7, 32'h09);
    waitst(0, n);
    repeat (2) tick();
    chkv(highSpeedAllowed, 32'h0, "full speed only");
    strobe(7, 32'h0B);
    repeat (3) tick();
    waitst(0, n);
    repeat (2) tick();
    chkv(highSpeedAllowed, 32'h1, "high speed");
    strobe(4, 32'h1);
    repeat (3) tick();
    chkv(irq, 32'h1, "lock interrupt");
    strobe(5, 32'h1);
    repeat (3) tick();
    chkv(irq, 32'h0, "masked interrupt");
    // master ready and pll lock both stand here, so either mask bit raises the line
    strobe(4, 32'h6);
    repeat (3) tick();
    chkv(irq, 32'h1, "ready interrupt");
    strobe(5, 32'h6);
    repeat (3) tick();
    chkv(irq, 32'h0, "ready masked");
    // programmable outputs: every source, then prescale codes 0 to 6
    for (int s = 0; s < 4; s++) begin
      strobe(10, s);
      strobe(2, 32'h4);
      waitst(4, n);
      period(3, n);
      chkp(n, srcPer[s], srcPer[s], "output source");
      strobe(3, 32'h4);
      repeat (3) tick();
      chkv(powerStatus[4], 32'h0, "output ready");
    end
    for (int c = 0; c < 7; c++) begin
      strobe(9, {c[2:0], 2'h1});
      strobe(2, 32'h2);
      waitst(3, n);
      chkp(n, 1, 6 * 66 + 8, "output latency");
      period(2, n);
      chkp(n, 6 << c, 6 << c, "output prescale");
      strobe(3, 32'h2);
    end
    reset_run(2);
    stop_test();
  end
endmodule
`default_nettype wire
